/* dcc_regs.svh */
// Field positions, reset values and timing counts of the comparator block
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_CTL_SINGLE      0
`define DCC_CTL_HYST        1
`define DCC_CTL_SPEED       2
`define DCC_CTL_INTERRUPT_SOURCE_SELECT_LO   3
`define DCC_CTL_INTERRUPT_SOURCE_SELECT_HI   4
`define DCC_CTL_FILT        5
`define DCC_CTL_STDBY       6
`define DCC_CTL_POS_LO      7
`define DCC_CTL_POS_HI      8
`define DCC_CTL_NEG_LO      9
`define DCC_CTL_NEG_HI      11
`define DCC_CTL_SCALE_LO    12
`define DCC_CTL_SCALE_HI    17
`define DCC_CTL_W           18
`define DCC_CTL_RST         18'h00000
`define DCC_EVC_W           4
`define DCC_EVC_RST         4'h0
`define DCC_WIN_RST         3'h0
`define DCC_FILT_LEN        3
`define DCC_STARTUP_CYC     4
`endif

/* dcc_pkg.sv */
// Types shared by the comparator block modules
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_INT_TOGGLE, DCC_INT_RISE, DCC_INT_FALL, DCC_INT_EOC
  } dcc_interrupt_source_select_t;
  typedef enum logic [1:0] {
    DCC_WIN_ABOVE, DCC_WIN_INSIDE, DCC_WIN_BELOW, DCC_WIN_OUTSIDE
  } dcc_winsel_t;
  typedef enum logic [2:0] {
    DCC_IN_PIN0, DCC_IN_PIN1, DCC_IN_PIN2, DCC_IN_PIN3,
    DCC_IN_GND, DCC_IN_BANDGAP, DCC_IN_DAC, DCC_IN_VSCALE
  } dcc_insel_t;
  typedef enum {DCC_CH_OFF, DCC_CH_START, DCC_CH_RUN, DCC_CH_DONE} dcc_chst_t;
endpackage

/* dcc_chan_if.sv */
// Signals between the block top and one comparator channel
`timescale 1ns/100ps
`default_nettype none
interface dcc_chan_if;
  logic [17:0] cfg;
  logic        run;
  logic        start;
  logic        raw;
  logic        result;
  logic        sample;
  logic        eoc;
  logic        ready;
  logic        intr;
  modport top (output cfg, run, start, raw,
               input result, sample, eoc, ready, intr);
  modport chan (input cfg, run, start, raw,
                output result, sample, eoc, ready, intr);
endinterface
`default_nettype wire

/* dcc_chan.sv */
// One comparator channel: startup, sampling, filter and interrupt source
`timescale 1ns/100ps
`default_nettype none
`include "dcc_regs.svh"
module dcc_chan
  import dcc_pkg::*;
#(
  parameter int FILT_LEN    = `DCC_FILT_LEN,
  parameter int STARTUP_CYC = `DCC_STARTUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Channel link
  dcc_chan_if.chan ch
);
  typedef struct packed {
    dcc_chst_t         st;
    logic [7:0]        cnt;
    logic [FILT_LEN-1:0] hist;
    logic              res;
    logic              prev;
    logic              valid;
    logic              ready;
    logic              eoc;
    logic              intr;
    logic              sample;
  } dcc_ch_state_t;
  dcc_ch_state_t cur_ff, nxt_s;
  logic          filt_bit;
  logic          single;
  dcc_interrupt_source_select_t   isel;

  // Majority of history: a lone glitch never flips the result
  function automatic logic majority(input logic [FILT_LEN-1:0] v);
    int ones;
    ones = 0;
    for (int i = 0; i < FILT_LEN; i++) ones += int'(v[i]);
    return (2 * ones) > FILT_LEN;
  endfunction

  assign single = ch.cfg[`DCC_CTL_SINGLE];
  assign isel   = dcc_interrupt_source_select_t'(ch.cfg[`DCC_CTL_INTERRUPT_SOURCE_SELECT_HI:`DCC_CTL_INTERRUPT_SOURCE_SELECT_LO]);
  assign filt_bit = ch.cfg[`DCC_CTL_FILT] ?
                    majority({cur_ff.hist[FILT_LEN-2:0], ch.raw}) :
                    ch.raw;

  always_comb begin
    nxt_s        = cur_ff;
    nxt_s.eoc    = 1'b0;
    nxt_s.intr   = 1'b0;
    nxt_s.sample = 1'b0;
    nxt_s.hist   = {cur_ff.hist[FILT_LEN-2:0], ch.raw};
    case (cur_ff.st)
      DCC_CH_OFF: begin
        nxt_s.valid = 1'b0;
        if (ch.run && (!single || ch.start)) begin
          nxt_s.st    = DCC_CH_START;
          nxt_s.cnt   = 8'(STARTUP_CYC);
          nxt_s.ready = 1'b0;
        end
      end
      DCC_CH_START: begin
        nxt_s.cnt = cur_ff.cnt - 8'h01;
        if (cur_ff.cnt == 8'h01) nxt_s.st = DCC_CH_RUN;
      end
      DCC_CH_RUN: begin
        // Sample at every digital clock edge
        nxt_s.res    = filt_bit;
        nxt_s.prev   = cur_ff.res;
        nxt_s.valid  = 1'b1;
        nxt_s.sample = 1'b1;
        nxt_s.ready  = 1'b1;
        if (single) begin
          nxt_s.eoc = 1'b1;
          nxt_s.st  = DCC_CH_DONE;
        end
        case (isel)
          DCC_INT_TOGGLE: nxt_s.intr = cur_ff.valid && (filt_bit != cur_ff.res);
          DCC_INT_RISE:   nxt_s.intr = cur_ff.valid && filt_bit && !cur_ff.res;
          DCC_INT_FALL:   nxt_s.intr = cur_ff.valid && !filt_bit && cur_ff.res;
          DCC_INT_EOC:    nxt_s.intr = single;
          default:        nxt_s.intr = 1'b0;
        endcase
      end
      DCC_CH_DONE: begin
        if (ch.start) begin
          nxt_s.st    = DCC_CH_START;
          nxt_s.cnt   = 8'(STARTUP_CYC);
          nxt_s.ready = 1'b0;
        end
        if (!single) nxt_s.st = DCC_CH_RUN;
      end
      default: nxt_s.st = DCC_CH_OFF;
    endcase
    if (!ch.run) begin
      nxt_s.st = DCC_CH_OFF;
      if (!single) nxt_s.ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_s;
    end
  end

  assign ch.result = cur_ff.res;
  assign ch.sample = cur_ff.sample;
  assign ch.eoc    = cur_ff.eoc;
  assign ch.ready  = cur_ff.ready;
  assign ch.intr   = cur_ff.intr;
endmodule // dcc_chan
`default_nettype wire

/* dcc_top.sv */
// Digital control for the dual comparator block
`timescale 1ns/100ps
`default_nettype none
`include "dcc_regs.svh"
module dcc_top
  import dcc_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Control one
  input  wire logic                 wr_control_one,
  input  wire logic                 global_enable_in,
  input  wire logic                 soft_reset_bit,
  // Per-comparator control
  input  wire logic [NCH-1:0]       wr_comp_ctl,
  input  wire logic [`DCC_CTL_W-1:0] comp_ctl_in,
  input  wire logic [NCH-1:0]       wr_comp_en,
  input  wire logic                 comp_en_in,
  // Event control, window and debug settings
  input  wire logic                 wr_event_control,
  input  wire logic [`DCC_EVC_W-1:0] event_control_in,
  input  wire logic                 wr_window,
  input  wire logic [2:0]           window_in,
  input  wire logic                 wr_debug,
  input  wire logic                 debug_halt_in,
  // Access qualifiers
  input  wire logic                 write_protect,
  input  wire logic                 debugger_access,
  input  wire logic                 cpu_halted,
  // Control two: start comparison bits
  input  wire logic [NCH-1:0]       start_comparison_bit,
  input  wire logic [NCH-1:0]       start_event_in,
  // Analog comparator raw outputs, asynchronous
  input  wire logic [NCH-1:0]       comp_raw_async,
  // Settings to the analog side
  output logic [NCH*`DCC_CTL_W-1:0] comp_ctl_out,
  output logic [NCH-1:0]            comp_power_on,
  output logic                      block_enabled,
  output logic [`DCC_EVC_W-1:0]     event_control_out,
  output logic [2:0]                window_out,
  output logic                      debug_halt_out,
  // Status and results
  output logic [NCH-1:0]            comp_state,
  output logic [NCH-1:0]            comparison_ready_flag,
  output logic [1:0]                window_state,
  output logic                      sync_busy,
  output logic [NCH-1:0]            comp_int_pulse,
  output logic                      window_int_pulse,
  output logic [NCH-1:0]            comp_event,
  output logic                      window_event,
  output logic [NCH-1:0]            comparator_output_pins
);
  typedef struct packed {
    logic                           en;
    logic [NCH-1:0]                 comp_en;
    logic [NCH-1:0][`DCC_CTL_W-1:0] ctl;
    logic [`DCC_EVC_W-1:0]          evc;
    logic [2:0]                     win;
    logic                           dbg_halt;
    logic [NCH-1:0]                 sync1;
    logic [NCH-1:0]                 sync2;
    logic [1:0]                     busy_cnt;
    logic [NCH-1:0]                 start_pend;
    logic                           win_inside;
    logic [1:0]                     wstate;
    logic                           win_valid;
    logic                           win_int;
    logic                           win_evt;
    logic [NCH-1:0]                 cevt;
    logic [NCH-1:0]                 pins;
  } dcc_state_t;
  dcc_state_t cur_ff, nxt_s;
  logic [NCH-1:0] ch_res, ch_samp, ch_eoc, ch_rdy, ch_int;
  logic           halted;
  logic           wr_ok;
  logic [1:0]     wstate_now;

  assign wr_ok  = !write_protect || debugger_access;
  assign halted = cpu_halted && cur_ff.dbg_halt;

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      dcc_chan_if cif ();
      assign cif.cfg   = cur_ff.ctl[g];
      assign cif.run   = cur_ff.en && cur_ff.comp_en[g] && !halted;
      assign cif.start = cur_ff.start_pend[g];
      assign cif.raw   = cur_ff.sync2[g];
      assign ch_res[g]  = cif.result;
      assign ch_samp[g] = cif.sample;
      assign ch_eoc[g]  = cif.eoc;
      assign ch_rdy[g]  = cif.ready;
      assign ch_int[g]  = cif.intr;
      dcc_chan u_chan (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ch      (cif.chan)
      );
    end
  endgenerate

  // Window code: 0 above, 1 inside, 2 below from the two results
  function automatic logic [1:0] win_code(input logic a, input logic b);
    if (a && b) return 2'h0;
    if (a != b) return 2'h1;
    return 2'h2;
  endfunction

  assign wstate_now = win_code(ch_res[0], ch_res[1]);

  always_comb begin
    nxt_s         = cur_ff;
    nxt_s.win_int = 1'b0;
    nxt_s.win_evt = 1'b0;
    // Raw comparator levels cross into the clock domain
    nxt_s.sync1 = comp_raw_async;
    nxt_s.sync2 = cur_ff.sync1;
    nxt_s.start_pend = start_comparison_bit |
                       (start_event_in & cur_ff.evc[NCH-1:0]);
    if (cur_ff.busy_cnt != 2'h0) nxt_s.busy_cnt = cur_ff.busy_cnt - 2'h1;
    if (wr_control_one && wr_ok) begin
      nxt_s.en       = global_enable_in;
      nxt_s.busy_cnt = 2'h2;
    end
    for (int i = 0; i < NCH; i++) begin
      // Config only changes while the comparator is off, or by soft reset
      if (wr_comp_ctl[i] && wr_ok && !(cur_ff.en && cur_ff.comp_en[i]))
        nxt_s.ctl[i] = comp_ctl_in;
      if (wr_comp_en[i] && wr_ok) begin
        nxt_s.comp_en[i] = comp_en_in;
        nxt_s.busy_cnt   = 2'h2;
      end
    end
    if (wr_event_control && wr_ok && !cur_ff.en)
      nxt_s.evc = event_control_in;
    if (wr_window && wr_ok && !cur_ff.en)
      nxt_s.win = window_in;
    if (wr_debug && wr_ok && !cur_ff.en)
      nxt_s.dbg_halt = debug_halt_in;
    // Window updates on channel 0 samples only, using the latest result of both channels
    if (cur_ff.win[0] && ch_samp[0]) begin
      nxt_s.wstate     = wstate_now;
      nxt_s.win_inside = wstate_now == 2'h1;
      nxt_s.win_valid  = 1'b1;
      if (cur_ff.win_valid && wstate_now != cur_ff.wstate) begin
        case (dcc_winsel_t'(cur_ff.win[2:1]))
          DCC_WIN_ABOVE:   nxt_s.win_int = wstate_now == 2'h0;
          DCC_WIN_INSIDE:  nxt_s.win_int = wstate_now == 2'h1;
          DCC_WIN_BELOW:   nxt_s.win_int = wstate_now == 2'h2;
          DCC_WIN_OUTSIDE: nxt_s.win_int = wstate_now != 2'h1;
          default:         nxt_s.win_int = 1'b0;
        endcase
        nxt_s.win_evt = cur_ff.evc[NCH];
      end
    end
    if (!cur_ff.win[0]) nxt_s.win_valid = 1'b0;
    // Events need no wake, they follow samples
    nxt_s.cevt = (ch_samp | ch_eoc) & {NCH{cur_ff.evc[NCH+1]}};
    // Pin: direct synced level or registered result
    nxt_s.pins = cur_ff.ctl[0][`DCC_CTL_STDBY] ? cur_ff.sync2 : ch_res;
    if (soft_reset_bit && wr_ok) begin
      nxt_s          = '0;
      nxt_s.ctl      = {NCH{`DCC_CTL_RST}};
      nxt_s.evc      = `DCC_EVC_RST;
      nxt_s.win      = `DCC_WIN_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_s;
    end
  end

  // Outputs registered; ready/interrupt from channel flip-flops
  logic [NCH-1:0] rdy_ff, int_ff, st_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdy_ff <= '0;
      int_ff <= '0;
      st_ff  <= '0;
    end else begin
      rdy_ff <= ch_rdy;
      int_ff <= ch_int;
      st_ff  <= ch_res;
    end
  end

  assign comp_ctl_out          = cur_ff.ctl;
  assign comp_power_on         = cur_ff.comp_en & {NCH{cur_ff.en}};
  assign block_enabled         = cur_ff.en;
  assign event_control_out     = cur_ff.evc;
  assign window_out            = cur_ff.win;
  assign debug_halt_out        = cur_ff.dbg_halt;
  assign comp_state            = st_ff;
  assign comparison_ready_flag = rdy_ff;
  assign window_state          = cur_ff.wstate;
  assign sync_busy             = cur_ff.busy_cnt != 2'h0;
  assign comp_int_pulse        = int_ff;
  assign window_int_pulse      = cur_ff.win_int;
  assign comp_event            = cur_ff.cevt;
  assign window_event          = cur_ff.win_evt;
  assign comparator_output_pins = cur_ff.pins;
endmodule // dcc_top
`default_nettype wire

/* dcc_properties.sv */
// Concurrent checks on the comparator block top-level ports
`timescale 1ns/100ps
`default_nettype none
`include "dcc_regs.svh"
module dcc_properties #(
  parameter int NCH = 2
) (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic                       wr_control_one,
  input wire logic                       global_enable_in,
  input wire logic                       soft_reset_bit,
  input wire logic                       write_protect,
  input wire logic                       debugger_access,
  input wire logic [NCH-1:0]             start_comparison_bit,
  input wire logic [NCH*`DCC_CTL_W-1:0]  comp_ctl_out,
  input wire logic [NCH-1:0]             comp_power_on,
  input wire logic                       block_enabled,
  input wire logic [`DCC_EVC_W-1:0]      event_control_out,
  input wire logic [2:0]                 window_out,
  input wire logic                       debug_halt_out,
  input wire logic [NCH-1:0]             comparison_ready_flag,
  input wire logic                       sync_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic allowed;
  assign allowed = !write_protect || debugger_access;

  sequence s_start0;
    start_comparison_bit[0] && block_enabled && comp_ctl_out[0];
  endsequence
  sequence s_ready_cycle0;
    // Ready may still show the last result for two cycles after a restart
    ##[0:2] !comparison_ready_flag[0] ##[1:40] comparison_ready_flag[0];
  endsequence

  chk_enable_takes: assert property (
    wr_control_one && global_enable_in && allowed && !soft_reset_bit
    |=> block_enabled) else $error("enable write not taken");
  chk_disable_takes: assert property (
    wr_control_one && !global_enable_in && allowed |=> !block_enabled)
    else $error("disable write not taken");
  chk_soft_reset_clears: assert property (
    soft_reset_bit && allowed |=> !block_enabled && comp_ctl_out == '0
    && event_control_out == '0 && window_out == 3'h0 && !debug_halt_out)
    else $error("soft reset left settings");
  chk_evc_frozen: assert property (
    block_enabled && !soft_reset_bit |=> $stable(event_control_out)
    && $stable(window_out) && $stable(debug_halt_out))
    else $error("event settings changed while enabled");
  chk_ctl0_frozen: assert property (
    comp_power_on[0] && !soft_reset_bit |=> $stable(comp_ctl_out[17:0]))
    else $error("first comparator settings changed while on");
  chk_ctl1_frozen: assert property (
    comp_power_on[1] && !soft_reset_bit |=> $stable(comp_ctl_out[35:18]))
    else $error("second comparator settings changed while on");
  chk_protect_blocks: assert property (
    wr_control_one && write_protect && !debugger_access
    |=> $stable(block_enabled)) else $error("protected write took effect");
  chk_busy_after_enable: assert property (
    wr_control_one && global_enable_in && allowed && !soft_reset_bit
    |=> sync_busy) else $error("no busy after enable write");
  chk_off_when_disabled: assert property (
    !block_enabled ##1 !block_enabled |-> comp_power_on == '0)
    else $error("comparator powered while block disabled");
  chk_ready_cycle: assert property (
    s_start0 |=> s_ready_cycle0) else $error("ready flag did not cycle");
endmodule // dcc_properties
`default_nettype wire

/* dcc_analog_model.sv */
// Behavioural model of the analog comparator front ends
`timescale 1ns/100ps
`default_nettype none
module dcc_analog_model (
  input  wire logic        clk,
  input  wire logic [1:0]  power,
  input  wire logic [11:0] pos_mv [2],
  input  wire logic [11:0] neg_mv [2],
  output logic [1:0]       raw
);
  // Unpowered outputs wander so a stale level is never trusted
  logic scramble = 1'b0;
  always @(posedge clk) scramble <= ~scramble;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (power[i])
        raw[i] = pos_mv[i] > neg_mv[i];
      else
        raw[i] = scramble ^ i[0];
    end
  end
endmodule // dcc_analog_model
`default_nettype wire

/* dual_comparator_control_bench.sv */
// Self-checking bench for the comparator block control
`timescale 1ns/100ps
`default_nettype none
`include "dcc_regs.svh"
module dual_comparator_control_bench;
  logic clk, sys_rst = 1'b1, wr_control_one = 0, global_enable_in = 0;
  logic soft_reset_bit = 0, wr_event_control = 0, wr_window = 0;
  logic wr_debug = 0, debug_halt_in = 0, write_protect = 0;
  logic debugger_access = 0, cpu_halted = 0;
  logic [1:0] wr_comp_ctl = 0, wr_comp_en = 0, start_comparison_bit = 0;
  logic comp_en_in = 0;
  logic [17:0] comp_ctl_in = 0;
  logic [3:0] event_control_in = 0;
  logic [2:0] window_in = 0, window_out;
  logic [1:0] comp_raw_async, comp_power_on, comp_state;
  logic [1:0] comparison_ready_flag, window_state, comp_int_pulse;
  logic [1:0] comp_event, comparator_output_pins;
  logic [35:0] comp_ctl_out;
  logic [3:0] event_control_out;
  logic block_enabled, debug_halt_out, sync_busy, window_int_pulse;
  logic window_event;
  logic [11:0] pos_mv [2];
  logic [11:0] neg_mv [2];
  int failures = 0, num_checks = 0, int_cnt = 0, cycles = 0;

  dcc_top #(.NCH(2)) i_dcc_top (.clk, .sys_rst, .wr_control_one,
    .global_enable_in, .soft_reset_bit, .wr_comp_ctl, .comp_ctl_in,
    .wr_comp_en, .comp_en_in, .wr_event_control, .event_control_in,
    .wr_window, .window_in, .wr_debug, .debug_halt_in, .write_protect,
    .debugger_access, .cpu_halted, .start_comparison_bit,
    .start_event_in(2'h0), .comp_raw_async, .comp_ctl_out, .comp_power_on,
    .block_enabled, .event_control_out, .window_out, .debug_halt_out,
    .comp_state, .comparison_ready_flag, .window_state, .sync_busy,
    .comp_int_pulse, .window_int_pulse, .comp_event, .window_event,
    .comparator_output_pins);
  dcc_analog_model i_dcc_analog_model (.clk, .power(comp_power_on),
    .pos_mv, .neg_mv, .raw(comp_raw_async));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (comp_int_pulse[0] === 1'b1) int_cnt <= int_cnt + 1;
    cycles <= cycles + 1;
    // Whole run needs about 200 cycles
    if (cycles == 5000) begin
      failures++;
      $display("ERROR at %0t ns: run hung", $time);
      end_sim();
    end
  end

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      failures++;
      $display("ERROR at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Write tasks start on a falling edge and end on the next one
  task automatic w_ctl1(input logic en);
    wr_control_one = 1'b1;
    global_enable_in = en;
    idle(1);
    wr_control_one = 1'b0;
  endtask
  task automatic w_cc(input logic [1:0] m, input logic [17:0] d);
    wr_comp_ctl = m;
    comp_ctl_in = d;
    idle(1);
    wr_comp_ctl = 2'h0;
  endtask
  task automatic w_en(input logic [1:0] m, input logic en);
    wr_comp_en = m;
    comp_en_in = en;
    idle(1);
    wr_comp_en = 2'h0;
  endtask
  task automatic w_evc(input logic [3:0] e, input logic [2:0] w,
                       input logic d);
    {wr_event_control, wr_window, wr_debug} = 3'h7;
    {event_control_in, window_in, debug_halt_in} = {e, w, d};
    idle(1);
    {wr_event_control, wr_window, wr_debug} = 3'h0;
  endtask
  task automatic all_clear(input string msg);
    chk({block_enabled, comp_power_on, event_control_out, window_out,
         debug_halt_out, comp_ctl_out} === '0, msg);
  endtask

  task automatic t_lock;
    w_evc(4'hA, 3'h3, 1'b1);
    chk({event_control_out, window_out, debug_halt_out} === 8'hA7, "cfg");
    w_ctl1(1'b1);
    chk(block_enabled === 1'b1 && sync_busy === 1'b1, "enable");
    w_evc(4'h5, 3'h0, 1'b0);
    chk({event_control_out, window_out} === 7'h53, "evc unlocked");
    w_ctl1(1'b0);
    chk(block_enabled === 1'b0, "disable");
    w_evc(4'h0, 3'h0, 1'b0);
    $display("t_lock done");
  endtask
  task automatic t_protect;
    write_protect = 1'b1;
    w_ctl1(1'b1);
    w_evc(4'h3, 3'h1, 1'b0);
    chk(block_enabled === 1'b0, "protected enable");
    chk(event_control_out === 4'h0, "protected evc");
    debugger_access = 1'b1;
    w_ctl1(1'b1);
    chk(block_enabled === 1'b1, "debugger write lost");
    idle(1);
    w_ctl1(1'b0);
    {write_protect, debugger_access} = 2'h0;
    $display("t_protect done");
  endtask
  task automatic t_continuous;
    {pos_mv[0], neg_mv[0], pos_mv[1], neg_mv[1]} = {12'd100, 12'd200,
                                                     12'd300, 12'd200};
    w_cc(2'b11, 18'h00008);
    w_en(2'b11, 1'b1);
    w_ctl1(1'b1);
    idle(20);
    chk(comp_state === 2'b10, "result levels");
    w_cc(2'b01, 18'h00010);
    chk(comp_ctl_out[17:0] === 18'h00008, "cfg unlocked");
    int_cnt = 0;
    pos_mv[0] = 12'd300;
    idle(20);
    chk(int_cnt === 1 && comp_state[0] === 1'b1, "rise irq");
    pos_mv[0] = 12'd100;
    idle(20);
    chk(int_cnt === 1, "irq on fall");
    w_ctl1(1'b0);
    idle(2);
    chk(comp_power_on === 2'b00, "on while disabled");
    w_ctl1(1'b1);
    idle(2);
    chk(comp_power_on === 2'b11, "enables lost");
    w_en(2'b10, 1'b0);
    idle(2);
    chk(comp_power_on === 2'b01, "not independent");
    w_en(2'b01, 1'b0);
    w_ctl1(1'b0);
    $display("t_continuous done");
  endtask
  task automatic t_single;
    pos_mv[0] = 12'd300;
    w_cc(2'b01, 18'h00019);
    w_en(2'b01, 1'b1);
    w_ctl1(1'b1);
    idle(20);
    int_cnt = 0;
    start_comparison_bit = 2'b01;
    idle(1);
    start_comparison_bit = 2'b00;
    chk(comparison_ready_flag[0] === 1'b0, "ready not cleared");
    for (int i = 0; i < 40 && comparison_ready_flag[0] !== 1'b1; i++)
      idle(1);
    chk(comparison_ready_flag[0] === 1'b1, "ready not set");
    idle(3);
    chk(comp_state[0] === 1'b1 && int_cnt === 1, "end irq");
    // Restart from the done state, where ready is still set
    start_comparison_bit = 2'b01;
    idle(1);
    start_comparison_bit = 2'b00;
    idle(2);
    chk(comparison_ready_flag[0] === 1'b0, "restart kept ready");
    idle(10);
    chk(comparison_ready_flag[0] === 1'b1, "no ready again");
    w_en(2'b01, 1'b0);
    w_ctl1(1'b0);
    $display("t_single done");
  endtask
  task automatic t_window;
    int wi, we, ce;
    wi = 0;
    we = 0;
    ce = 0;
    {pos_mv[0], neg_mv[0], pos_mv[1], neg_mv[1]} = {12'd300, 12'd200,
                                                     12'd300, 12'd100};
    w_evc(4'hC, 3'h3, 1'b0);
    w_cc(2'b11, 18'h00000);
    w_en(2'b11, 1'b1);
    w_ctl1(1'b1);
    idle(20);
    chk(window_state === 2'h0, "not above");
    pos_mv[0] = 12'd150;
    pos_mv[1] = 12'd150;
    repeat (20) begin
      idle(1);
      if (window_int_pulse === 1'b1) wi++;
      if (window_event === 1'b1) we++;
      if (comp_event === 2'b11) ce++;
    end
    chk(window_state === 2'h1 && wi == 1, "inside irq");
    chk(we == 1 && ce == 20, "events");
    chk(comparator_output_pins === 2'b10, "pins");
    w_en(2'b11, 1'b0);
    w_ctl1(1'b0);
    w_evc(4'h0, 3'h0, 1'b0);
    $display("t_window done");
  endtask
  task automatic t_soft_reset;
    w_evc(4'h6, 3'h1, 1'b1);
    w_cc(2'b11, 18'h3F000);
    w_ctl1(1'b1);
    soft_reset_bit = 1'b1;
    idle(1);
    soft_reset_bit = 1'b0;
    all_clear("soft reset");
    $display("t_soft_reset done");
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {pos_mv[0], neg_mv[0], pos_mv[1], neg_mv[1]} = '0;
    idle(10);
    sys_rst = 1'b0;
    all_clear("reset values");
    t_lock();
    t_protect();
    t_continuous();
    t_single();
    t_window();
    t_soft_reset();
    end_sim();
  end
endmodule // dual_comparator_control_bench

bind dcc_top dcc_properties #(.NCH(NCH)) i_dcc_properties (.clk, .sys_rst,
  .wr_control_one, .global_enable_in, .soft_reset_bit, .write_protect,
  .debugger_access, .start_comparison_bit, .comp_ctl_out, .comp_power_on,
  .block_enabled, .event_control_out, .window_out, .debug_halt_out,
  .comparison_ready_flag, .sync_busy);
`default_nettype wire
